// ===== core/addr_compare.sv
`timescale 1ns/1ps
`default_nettype none
module addr_compare
	import i2c_slave_pkg::*;
#(
	parameter bit HAS_QUAL = 1'b0
) (
	input wire cmp_cfg_t cfg,
	input wire qual_cfg_t qual,
	input wire logic [6:0] rx_addr,
	output logic hit
);
	// a programmed zero matches the general call naturally through the exact compare
	always_comb begin
		hit = 1'b0;
		if (!cfg.off) begin
			if (HAS_QUAL && qual.range_mode) begin
				hit = (rx_addr >= cfg.addr) && (rx_addr <= qual.value);
			end else if (HAS_QUAL) begin
				hit = ((rx_addr ^ cfg.addr) & ~qual.value) == 7'h00;
			end else begin
				hit = rx_addr == cfg.addr;
			end
		end
	end
endmodule : addr_compare
`default_nettype wire

// ===== core/i2c_slave_addr_match_data.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_addr_match_data
	import i2c_slave_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic irq
);
	// ----------------------------------------
	// pin synchronisers and filter
	// ----------------------------------------
	logic [1:0] pin_s1_q;
	logic [1:0] pin_s2_q;
	logic [1:0] pin_s3_q;
	logic [1:0] pin_f_q;
	logic [1:0] pin_p_q;

	genvar gp;
	generate
		for (gp = 0; gp < 2; gp++) begin : g_sync
			always_ff @(posedge ref_clk) begin
				if (reset) begin
					pin_s1_q[gp] <= 1'b1;
					pin_s2_q[gp] <= 1'b1;
					pin_s3_q[gp] <= 1'b1;
					pin_f_q[gp] <= 1'b1;
					pin_p_q[gp] <= 1'b1;
				end else if (ce) begin
					pin_s1_q[gp] <= (gp == 0) ? scl_in : sda_in;
					pin_s2_q[gp] <= pin_s1_q[gp];
					pin_s3_q[gp] <= pin_s2_q[gp];
					// a change counts only once stages two and three agree
					if (pin_s2_q[gp] == pin_s3_q[gp]) begin
						pin_f_q[gp] <= pin_s3_q[gp];
					end
					pin_p_q[gp] <= pin_f_q[gp];
				end
			end
		end
	endgenerate

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_rise = pin_f_q[0] && !pin_p_q[0];
	assign scl_fall = !pin_f_q[0] && pin_p_q[0];
	assign start_det = pin_f_q[0] && pin_p_q[0] && !pin_f_q[1] && pin_p_q[1];
	assign stop_det = pin_f_q[0] && pin_p_q[0] && pin_f_q[1] && !pin_p_q[1];

	// ----------------------------------------
	// registers
	// ----------------------------------------
	cmp_cfg_t cmp_cfg_q [NUM_CMP];
	qual_cfg_t qual_q;
	logic auto_ignore_addresses_q;
	logic auto_accept_header_q;
	logic expected_direction_q;
	logic [7:0] rx_data_q;
	logic [7:0] tx_data_q;
	logic [IRQ_W-1:0] irq_status_q;
	logic [IRQ_W-1:0] irq_status_d;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] events;

	logic wr_ctl;
	logic wr_data;
	logic wr_qual;
	logic wr_stat;
	logic wr_mask;
	assign wr_ctl = ce && reg_wr && (reg_addr == OFS_CONTROL);
	assign wr_data = ce && reg_wr && (reg_addr == OFS_SLAVE_DATA);
	assign wr_qual = ce && reg_wr && (reg_addr == OFS_QUALIFIER);
	assign wr_stat = ce && reg_wr && (reg_addr == OFS_IRQ_STATUS);
	assign wr_mask = ce && reg_wr && (reg_addr == OFS_IRQ_MASK);

	localparam logic [7:0] CMP_OFS [NUM_CMP] = '{OFS_ADDRESS_ZERO, OFS_ADDRESS_ONE, OFS_ADDRESS_TWO, OFS_ADDRESS_THREE};

	// ----------------------------------------
	// comparators
	// ----------------------------------------
	logic [7:0] addr_shift_q;
	logic [NUM_CMP-1:0] cmp_hit;

	genvar gc;
	generate
		for (gc = 0; gc < NUM_CMP; gc++) begin : g_cmp
			always_ff @(posedge ref_clk) begin
				if (reset) begin
					cmp_cfg_q[gc] <= cmp_cfg_t'(RST_ADDRESS);
				end else if (ce && reg_wr && (reg_addr == CMP_OFS[gc])) begin
					cmp_cfg_q[gc] <= cmp_cfg_t'(reg_wdata[7:0]);
				end
			end

			addr_compare #(
				.HAS_QUAL(gc == 0)
			) u_cmp (
				.cfg(cmp_cfg_q[gc]),
				.qual(qual_q),
				.rx_addr(addr_shift_q[7:1]),
				.hit(cmp_hit[gc])
			);

			AST_CMP_OFF: assert property (@(posedge ref_clk) disable iff (reset) cmp_cfg_q[gc].off |-> !cmp_hit[gc])
				else $error("disabled comparator reported a hit");
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			auto_ignore_addresses_q <= 1'b0;
		end else if (ce && reg_wr && (reg_addr == OFS_ADDRESS_ZERO)) begin
			auto_ignore_addresses_q <= reg_wdata[BIT_AUTO_IGNORE];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			auto_accept_header_q <= 1'b0;
			expected_direction_q <= 1'b0;
		end else if (wr_ctl) begin
			auto_accept_header_q <= reg_wdata[BIT_AUTO_ACCEPT];
			expected_direction_q <= reg_wdata[BIT_EXPECTED_DIR];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			qual_q <= qual_cfg_t'(RST_QUALIFIER);
		end else if (wr_qual) begin
			qual_q <= qual_cfg_t'(reg_wdata[7:0]);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tx_data_q <= RST_TX_DATA;
		end else if (wr_data) begin
			tx_data_q <= reg_wdata[7:0];
		end
	end

	// ----------------------------------------
	// address decision
	// ----------------------------------------
	logic any_match;
	logic rw_bit;
	logic dir_ok;
	logic auto_take;
	logic accept;
	assign any_match = |cmp_hit;
	assign rw_bit = addr_shift_q[0];
	assign dir_ok = rw_bit == expected_direction_q;
	assign auto_take = auto_accept_header_q && cmp_hit[0] && dir_ok;
	// ignore bit only takes effect for headers not taken automatically
	assign accept = auto_take || (any_match && !auto_ignore_addresses_q);

	// ----------------------------------------
	// slave bus state machine
	// ----------------------------------------
	slave_state_t state_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic read_q;
	logic master_ack_q;
	logic sda_oe_q;
	logic decide;
	assign decide = ce && (state_q == ST_ADDR) && scl_fall && (bit_cnt_q == BITS_PER_BYTE) && !start_det && !stop_det;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q <= ST_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			addr_shift_q <= 8'h00;
			read_q <= 1'b0;
			master_ack_q <= 1'b0;
			sda_oe_q <= 1'b0;
			rx_data_q <= 8'h00;
		end else if (ce) begin
			if (start_det) begin
				state_q <= ST_ADDR;
				bit_cnt_q <= 4'h0;
				sda_oe_q <= 1'b0;
			end else if (stop_det) begin
				state_q <= ST_IDLE;
				sda_oe_q <= 1'b0;
			end else begin
				case (state_q)
					ST_IDLE: begin
						sda_oe_q <= 1'b0;
					end
					ST_ADDR: begin
						if (scl_rise) begin
							addr_shift_q <= {addr_shift_q[6:0], pin_f_q[1]};
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end else if (scl_fall && bit_cnt_q == BITS_PER_BYTE) begin
							read_q <= rw_bit;
							if (accept) begin
								sda_oe_q <= 1'b1;
								state_q <= ST_ACK;
							end else begin
								state_q <= ST_IDLE;
							end
						end
					end
					ST_ACK: begin
						if (scl_fall) begin
							bit_cnt_q <= 4'h0;
							if (read_q) begin
								shift_q <= tx_data_q;
								sda_oe_q <= !tx_data_q[7];
								state_q <= ST_TX;
							end else begin
								sda_oe_q <= 1'b0;
								state_q <= ST_RX;
							end
						end
					end
					ST_RX: begin
						if (scl_rise) begin
							shift_q <= {shift_q[6:0], pin_f_q[1]};
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end else if (scl_fall && bit_cnt_q == BITS_PER_BYTE) begin
							rx_data_q <= shift_q;
							sda_oe_q <= 1'b1;
							state_q <= ST_ACK;
						end
					end
					ST_TX: begin
						if (scl_rise) begin
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end else if (scl_fall) begin
							if (bit_cnt_q == BITS_PER_BYTE) begin
								sda_oe_q <= 1'b0;
								state_q <= ST_TX_ACK;
							end else begin
								shift_q <= {shift_q[6:0], 1'b1};
								sda_oe_q <= !shift_q[6];
							end
						end
					end
					ST_TX_ACK: begin
						if (scl_rise) begin
							master_ack_q <= !pin_f_q[1];
						end else if (scl_fall) begin
							bit_cnt_q <= 4'h0;
							if (master_ack_q) begin
								shift_q <= tx_data_q;
								sda_oe_q <= !tx_data_q[7];
								state_q <= ST_TX;
							end else begin
								state_q <= ST_IDLE;
							end
						end
					end
					default: begin
						state_q <= ST_IDLE;
						sda_oe_q <= 1'b0;
					end
				endcase
			end
		end
	end

	// open drain: the pin is only ever pulled low
	assign sda_out = 1'b0;
	assign sda_oe = sda_oe_q;

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	always_comb begin
		events = '0;
		events[EVT_ATTENTION] = decide && accept && !auto_take;
		events[EVT_RX_BYTE] = ce && (state_q == ST_RX) && scl_fall && (bit_cnt_q == BITS_PER_BYTE)
			&& !start_det && !stop_det;
		events[EVT_TX_BYTE] = ce && (state_q == ST_TX) && scl_fall && (bit_cnt_q == BITS_PER_BYTE)
			&& !start_det && !stop_det;
		events[EVT_STOP] = ce && stop_det && (state_q != ST_IDLE);
	end

	// a new event wins over a write-one clear in the same cycle
	always_comb begin
		irq_status_d = irq_status_q;
		if (wr_stat) begin
			irq_status_d = irq_status_d & ~reg_wdata[IRQ_W-1:0];
		end
		irq_status_d = irq_status_d | events;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq_status_q <= '0;
		end else if (ce) begin
			irq_status_q <= irq_status_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq_mask_q <= '0;
		end else if (wr_mask) begin
			irq_mask_q <= reg_wdata[IRQ_W-1:0];
		end
	end

	assign irq = |(irq_status_q & irq_mask_q);

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			reg_rdata <= 32'h0000_0000;
		end else if (ce && reg_rd) begin
			case (reg_addr)
				OFS_CONTROL: reg_rdata <= {30'h0, expected_direction_q, auto_accept_header_q};
				OFS_SLAVE_DATA: reg_rdata <= {24'h00_0000, rx_data_q};
				OFS_ADDRESS_ZERO: reg_rdata <= {16'h0000, auto_ignore_addresses_q, 7'h00, cmp_cfg_q[0]};
				OFS_ADDRESS_ONE: reg_rdata <= {24'h00_0000, cmp_cfg_q[1]};
				OFS_ADDRESS_TWO: reg_rdata <= {24'h00_0000, cmp_cfg_q[2]};
				OFS_ADDRESS_THREE: reg_rdata <= {24'h00_0000, cmp_cfg_q[3]};
				OFS_QUALIFIER: reg_rdata <= {24'h00_0000, qual_q};
				OFS_IRQ_STATUS: reg_rdata <= {28'h000_0000, irq_status_q};
				OFS_IRQ_MASK: reg_rdata <= {28'h000_0000, irq_mask_q};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	sequence s_header_taken;
		decide && accept;
	endsequence

	sequence s_acking;
		(state_q == ST_ACK) && sda_oe;
	endsequence

	AST_RX_READ: assert property (ce && reg_rd && reg_addr == OFS_SLAVE_DATA |=> reg_rdata == {24'h00_0000, $past(rx_data_q)})
		else $error("data read does not return the received byte");
	AST_TX_WRITE: assert property (wr_data |=> tx_data_q == $past(reg_wdata[7:0]))
		else $error("data write did not load the transmit byte");
	AST_IGNORE_ALL: assert property (decide && auto_ignore_addresses_q && !auto_accept_header_q |=> state_q == ST_IDLE && !sda_oe)
		else $error("address answered while ignoring all");
	AST_NO_MATCH: assert property (decide && !any_match |=> !sda_oe)
		else $error("unmatched address acknowledged");
	AST_ACCEPT: assert property (s_header_taken |=> s_acking)
		else $error("matched address not acknowledged");
	AST_NORMAL_MATCH: assert property (decide && any_match && !auto_ignore_addresses_q |=> s_acking)
		else $error("normal mode ignored a matching address");
	AST_AUTO_ACCEPT: assert property (decide && auto_accept_header_q && cmp_hit[0] && dir_ok |=> s_acking ##0 (!irq_status_q[EVT_ATTENTION] || $past(irq_status_q[EVT_ATTENTION])))
		else $error("automatic header not acknowledged");
	AST_ATTENTION: assert property (decide && any_match && !auto_ignore_addresses_q && !auto_accept_header_q |=> irq_status_q[EVT_ATTENTION])
		else $error("attention flag not raised");
	AST_RANGE: assert property (!cmp_cfg_q[0].off && qual_q.range_mode && addr_shift_q[7:1] >= cmp_cfg_q[0].addr && addr_shift_q[7:1] <= qual_q.value |-> cmp_hit[0])
		else $error("range qualifier missed an address");
	AST_ACK_RELEASE: assert property (s_acking ##0 (scl_fall && !start_det && !stop_det && ce && !read_q) |=> !sda_oe [*2])
		else $error("acknowledge not released after ninth clock");
endmodule : i2c_slave_addr_match_data
`default_nettype wire

// ===== core/i2c_slave_pkg.sv
// Summary of operation
// - reading the slave data register returns the byte last received from the bus master in bits 7 to 0.
// - writing bits 7 to 0 of the slave data register sets the byte sent to the bus master.
// - four independent address comparators recognise a received address in hardware.
// - only comparator zero uses the qualifier; comparators one to three do a plain exact compare.
// - any comparator programmed with address zero answers the general call address.
// - comparator zero compares its field in bits 7 to 1 when enabled, as modified by the qualifier.
// - with the ignore-addresses bit 15 clear, matching addresses are handled normally.
// - with bit 15 set and automatic accept clear, every incoming address is ignored.
// - bit 0 of comparator zero enables it when 0 and makes it ignored when 1.
// - comparator one compares bits 7 to 1, enabled when bit 0 is clear, ignored when set.
// - comparator two compares bits 7 to 1, enabled when bit 0 is clear, ignored when set.
// - comparator three compares bits 7 to 1, enabled when bit 0 is clear, ignored when set.
// - with automatic accept set, a header matching comparator zero and the expected direction is acknowledged at once.
// - with automatic accept and ignore both clear, a matching address raises the slave attention flag.
// - range mode matches from the programmed address up to the qualifier; mask mode forces set qualifier bits to match.
package i2c_slave_pkg;
	localparam int NUM_CMP = 4;
	localparam int ADDR_W = 8;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CONTROL = 8'h40;
	localparam logic [7:0] OFS_SLAVE_DATA = 8'h44;
	localparam logic [7:0] OFS_ADDRESS_ZERO = 8'h48;
	localparam logic [7:0] OFS_ADDRESS_ONE = 8'h4C;
	localparam logic [7:0] OFS_ADDRESS_TWO = 8'h50;
	localparam logic [7:0] OFS_ADDRESS_THREE = 8'h54;
	localparam logic [7:0] OFS_QUALIFIER = 8'h58;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h60;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h64;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int BIT_COMPARATOR_OFF = 0;
	localparam int BIT_AUTO_IGNORE = 15;
	localparam int BIT_AUTO_ACCEPT = 0;
	localparam int BIT_EXPECTED_DIR = 1;
	localparam int BIT_QUAL_KIND = 0;
	localparam int IRQ_W = 4;
	localparam int EVT_ATTENTION = 0;
	localparam int EVT_RX_BYTE = 1;
	localparam int EVT_TX_BYTE = 2;
	localparam int EVT_STOP = 3;
	// ----------------------------------------
	// reset values and counts
	// ----------------------------------------
	localparam logic [7:0] RST_ADDRESS = 8'h01;
	localparam logic [7:0] RST_QUALIFIER = 8'h00;
	localparam logic [7:0] RST_TX_DATA = 8'hFF;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam int SYNC_STAGES = 3;

	typedef struct packed {
		logic [6:0] addr;
		logic off;
	} cmp_cfg_t;

	typedef struct packed {
		logic [6:0] value;
		logic range_mode;
	} qual_cfg_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ACK = 3'b010,
		ST_RX = 3'b011,
		ST_TX = 3'b100,
		ST_TX_ACK = 3'b101
	} slave_state_t;
endpackage : i2c_slave_pkg

// ===== testbench/i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// i2c bus master, scl stands high between frames
// ----------------------------------------
module i2c_master_model (
	output logic scl,
	output logic sda_low,
	input wire logic sda_bus
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// sda moves well inside scl low so the synchronisers never see it beside an scl edge
	task automatic put_bit(input logic b);
		#100 sda_low = !b;
		#150 scl = 1'b1;
		#150 scl = 1'b0;
	endtask : put_bit
	task automatic get_bit(output logic b);
		#100 sda_low = 1'b0;
		#150 scl = 1'b1;
		#100 b = sda_bus;
		#50 scl = 1'b0;
	endtask : get_bit
	task automatic start();
		if (scl === 1'b0) begin
			#100 sda_low = 1'b0;
			#150 scl = 1'b1;
		end
		#150 sda_low = 1'b1;
		#150 scl = 1'b0;
	endtask : start
	task automatic stop();
		#100 sda_low = 1'b1;
		#150 scl = 1'b1;
		#150 sda_low = 1'b0;
		#100;
	endtask : stop
	task automatic write_byte(input logic [7:0] b, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			put_bit(b[i]);
		end
		get_bit(a);
		ack = !a;
	endtask : write_byte
	task automatic read_byte(input logic nack, output logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			get_bit(b[i]);
		end
		put_bit(nack);
	endtask : read_byte
endmodule : i2c_master_model
`default_nettype wire

// ===== testbench/i2c_slave_addr_match_data_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module i2c_slave_addr_match_data_tb_top import i2c_slave_pkg::*; ;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic [ADDR_W-1:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic scl;
	logic sda_low;
	logic sda_bus;
	logic sda_out;
	logic sda_oe;
	logic irq;
	int errors = 0;
	int samples_checked = 0;
	logic [31:0] r;
	// open drain with pull-up: low while either party pulls
	assign sda_bus = !(sda_low || sda_oe);
	always #25 ref_clk = ~ref_clk;
	i2c_slave_addr_match_data uut (.ref_clk(ref_clk), .reset(reset), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl),
		.sda_in(sda_bus), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
	i2c_master_model m (.scl(scl), .sda_low(sda_low), .sda_bus(sda_bus));
	// ----------------------------------------
	// register bus
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	// one frame on the bus, then the status and the received byte are judged
	task automatic xfer(input logic [6:0] a, input logic rw, input logic exp_ack, input logic [7:0] data,
		input logic [31:0] exp_stat);
		logic ack;
		logic [7:0] got;
		wr(OFS_IRQ_STATUS, 32'h0000000F);
		m.start();
		m.write_byte({a, rw}, ack);
		`CHK(ack, exp_ack)
		if (ack && !rw) begin
			m.write_byte(data, ack);
			`CHK(ack, 1'b1)
		end
		if (ack && rw) begin
			m.read_byte(1'b1, got);
			`CHK(got, data)
		end
		m.stop();
		repeat (8) @(posedge ref_clk);
		rd(OFS_IRQ_STATUS, r);
		`CHK(r, exp_stat)
		if (ack && !rw) begin
			rd(OFS_SLAVE_DATA, r);
			`CHK(r, {24'h0, data})
		end
	endtask : xfer
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		for (int k = 0; k < NUM_CMP; k++) begin
			rd(OFS_ADDRESS_ZERO + 8'(4 * k), r);
			`CHK(r, 32'h00000001)
		end
		rd(OFS_SLAVE_DATA, r);
		`CHK(r, 32'h0)
		rd(8'h7C, r);
		`CHK(r, 32'h0)
		`CHK({irq, sda_out}, 2'b00)
		wr(OFS_ADDRESS_ZERO, 32'h0000802A);
		rd(OFS_ADDRESS_ZERO, r);
		`CHK(r, 32'h0000802A)
		wr(OFS_ADDRESS_ZERO, 32'h00000001);
		wr(OFS_QUALIFIER, 32'h00000051);
		rd(OFS_QUALIFIER, r);
		`CHK(r, 32'h00000051)
		// a write with the clock enable low must leave the register untouched
		@(posedge ref_clk);
		ce <= 1'b0;
		wr(OFS_QUALIFIER, 32'h00000000);
		@(posedge ref_clk);
		ce <= 1'b1;
		rd(OFS_QUALIFIER, r);
		`CHK(r, 32'h00000051)
		wr(OFS_QUALIFIER, 32'h00000000);
	endtask : t_regs
	task automatic t_comparators();
		for (int k = 0; k < NUM_CMP; k++) begin
			wr(OFS_ADDRESS_ZERO + 8'(4 * k), {24'h0, 7'(7'h10 + k), 1'b1});
			xfer(7'(7'h10 + k), 1'b0, 1'b0, 8'h00, 32'h0);
			wr(OFS_ADDRESS_ZERO + 8'(4 * k), {24'h0, 7'(7'h10 + k), 1'b0});
			xfer(7'(7'h10 + k), 1'b0, 1'b1, 8'(8'h30 + k), 32'hB);
			wr(OFS_ADDRESS_ZERO + 8'(4 * k), 32'h00000001);
		end
		wr(OFS_ADDRESS_TWO, 32'h00000000);
		xfer(7'h00, 1'b0, 1'b1, 8'h5A, 32'hB);
		wr(OFS_ADDRESS_TWO, 32'h00000001);
	endtask : t_comparators
	task automatic t_auto();
		wr(OFS_ADDRESS_ZERO, 32'h0000802A);
		xfer(7'h15, 1'b0, 1'b0, 8'h00, 32'h0);
		wr(OFS_CONTROL, 32'h00000001);
		xfer(7'h15, 1'b0, 1'b1, 8'hC3, 32'hA);
		wr(OFS_CONTROL, 32'h00000000);
		wr(OFS_ADDRESS_ZERO, 32'h0000002A);
		xfer(7'h15, 1'b0, 1'b1, 8'h3C, 32'hB);
	endtask : t_auto
	task automatic t_qualifier();
		wr(OFS_ADDRESS_ZERO, 32'h00000040);
		wr(OFS_QUALIFIER, 32'h00000006);
		xfer(7'h23, 1'b0, 1'b1, 8'h81, 32'hB);
		xfer(7'h24, 1'b0, 1'b0, 8'h00, 32'h0);
		wr(OFS_ADDRESS_ONE, 32'h00000060);
		xfer(7'h31, 1'b0, 1'b0, 8'h00, 32'h0);
		wr(OFS_ADDRESS_ONE, 32'h00000001);
		wr(OFS_QUALIFIER, 32'h00000051);
		xfer(7'h28, 1'b0, 1'b1, 8'h7E, 32'hB);
		xfer(7'h29, 1'b0, 1'b0, 8'h00, 32'h0);
		wr(OFS_QUALIFIER, 32'h00000000);
		wr(OFS_ADDRESS_ZERO, 32'h00000001);
	endtask : t_qualifier
	task automatic t_read_irq();
		wr(OFS_ADDRESS_THREE, 32'h00000088);
		wr(OFS_SLAVE_DATA, 32'h000000A5);
		// the master's closing nack ends the exchange, so the later stop is not flagged
		xfer(7'h44, 1'b1, 1'b1, 8'hA5, 32'h5);
		`CHK(irq, 1'b0)
		wr(OFS_IRQ_MASK, 32'h00000004);
		`CHK(irq, 1'b1)
		wr(OFS_IRQ_STATUS, 32'h00000004);
		`CHK(irq, 1'b0)
	endtask : t_read_irq
	task automatic end_sim();
		$display("comparisons %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		t_regs();
		t_comparators();
		t_auto();
		t_qualifier();
		t_read_irq();
		end_sim();
	end
	// frames take at most about 8 us each; this is well beyond the whole sequence
	initial begin
		#3000000;
		errors++;
		end_sim();
	end
endmodule : i2c_slave_addr_match_data_tb_top
`default_nettype wire
